/* File: rtl/gate_timer_regs.vh */
`ifndef GATE_TIMER_REGS_VH
`define GATE_TIMER_REGS_VH

// register byte offsets
`define OFS_COUNTER_CTRL 8'h00
`define OFS_GATE_CTRL 8'h04
`define OFS_COUNT_LOW 8'h08
`define OFS_COUNT_HIGH 8'h0C
`define OFS_FLAGS 8'h10
`define OFS_IRQ_ENABLES 8'h14
`define OFS_SYSTEM_CTRL 8'h18
`define ADDR_MSB 7

// counter control fields
`define CC_ON 0
`define CC_EXT_CLK 1

// gate control fields
`define GC_GSS_LO 0
`define GC_GSS_HI 1
`define GC_GVAL 2
`define GC_GO_DONE 3
`define GC_SPM 4
`define GC_TM 5
`define GC_POL 6
`define GC_GE 7

// flag and enable fields
`define FL_OVERFLOW 0
`define FL_GATE 1

// system control fields
`define SC_PERIPH_IE 0
`define SC_GLOBAL_IE 1
`define SC_WDT_CFG 2

// gate source codes
`define GSS_PIN 2'b00
`define GSS_DIVIDER 2'b01
`define GSS_AUX 2'b10
`define GSS_WATCHDOG 2'b11

// constants
`define BYTE_WRAP_FROM 8'hFF
`define BYTE_WRAP_TO 8'h00
`define COUNT_MAX 16'hFFFF
`define COUNT_ONE 16'h0001
`define COUNT_ZERO 16'h0000
`define WORD_ZERO 32'h0000_0000

`endif

/* File: rtl/sync_two_flop.v */
`timescale 1ns/100ps
// two-stage synchroniser, one pair of flops per bit
module sync_two_flop #(
    parameter WIDTH = 3
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // bits from a foreign domain and their synchronised copy
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;

    // first stage feeds only the second
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta;
            reg stable;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta <= 1'b0;
                    stable <= 1'b0;
                end else begin
                    meta <= async_in[i];
                    stable <= meta;
                end
            end
            assign sync_out[i] = stable;
        end
    endgenerate

endmodule

/* File: rtl/gated_timer_gate_and_irq.v */
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
`include "gate_timer_regs.vh"
module gated_timer_gate_and_irq (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // external pins
    input wire gate_input,
    input wire count_clock,
    // on-chip gate sources, pclk domain
    input wire [7:0] divider_timer_count,
    input wire [7:0] aux_timer_count,
    input wire [7:0] aux_period_register,
    input wire aux_increment,
    // watchdog overflow, watchdog oscillator domain
    input wire watchdog_overflow,
    // watchdog control
    output reg watchdog_run,
    output reg watchdog_reset_enable,
    // interrupt requests
    output reg overflow_irq,
    output reg gate_event_irq,
    output reg irq_request
);

    // register state
    reg counter_on_bit;
    reg external_clock_select;
    reg gate_enable_bit;
    reg gate_polarity_bit;
    reg gate_toggle_mode_bit;
    reg gate_single_pulse_bit;
    reg pulse_acquire_go_done;
    reg [1:0] gate_source_select;
    reg [15:0] count;
    reg overflow_flag;
    reg gate_event_flag;
    reg overflow_irq_enable;
    reg gate_event_irq_enable;
    reg peripheral_irq_enable;
    reg global_irq_enable;
    reg watchdog_config_enable;

    // gate path state
    reg [7:0] divider_prev;
    reg divider_pulse, aux_pulse, source_prev, toggle_ff;
    reg stage_prev, pulse_window, gate_level_status;
    reg status_prev, clock_prev;

    // next values
    reg [15:0] next_count;
    reg next_go_done, next_overflow_flag, next_gate_event_flag;

    wire [2:0] synced;
    wire gate_pin_s, count_clock_s, watchdog_s;
    wire [`ADDR_MSB:0] addr;
    wire setup, wr, mapped;
    wire source_raw, source_pol, source_rise;
    wire gate_stage, stage_rise, stage_fall, gate_level;
    wire tick, count_enable, increment, rollover;

    // pins and watchdog into pclk domain
    sync_two_flop #(
        .WIDTH(3)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({watchdog_overflow, count_clock, gate_input}),
        .sync_out(synced)
    );

    assign gate_pin_s = synced[0];
    assign count_clock_s = synced[1];
    assign watchdog_s = synced[2];

    // bus decode, zero wait states
    assign addr = paddr[`ADDR_MSB:0];
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite && mapped; // aliases ignored
    assign mapped = (paddr[31:`ADDR_MSB+1] == 24'h00_0000) &&
        (addr == `OFS_COUNTER_CTRL || addr == `OFS_GATE_CTRL ||
         addr == `OFS_COUNT_LOW || addr == `OFS_COUNT_HIGH ||
         addr == `OFS_FLAGS || addr == `OFS_IRQ_ENABLES ||
         addr == `OFS_SYSTEM_CTRL);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // internal gate pulses from divider wrap and aux match
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider_prev <= `BYTE_WRAP_TO;
            divider_pulse <= 1'b0;
            aux_pulse <= 1'b0;
        end else begin
            divider_prev <= divider_timer_count;
            divider_pulse <= (divider_prev == `BYTE_WRAP_FROM) &&
                (divider_timer_count == `BYTE_WRAP_TO);
            aux_pulse <= aux_increment &&
                (aux_timer_count == aux_period_register);
        end
    end

    // source select and polarity
    assign source_raw =
        (gate_source_select == `GSS_PIN) ? gate_pin_s :
        (gate_source_select == `GSS_DIVIDER) ? divider_pulse :
        (gate_source_select == `GSS_AUX) ? aux_pulse :
        watchdog_s;
    assign source_pol = ~(source_raw ^ gate_polarity_bit);
    assign source_rise = source_pol && !source_prev;

    // toggle stage and single pulse window
    assign gate_stage = gate_toggle_mode_bit ? toggle_ff : source_pol;
    assign stage_rise = gate_stage && !stage_prev;
    assign stage_fall = !gate_stage && stage_prev;
    assign gate_level = gate_single_pulse_bit ?
        (gate_stage && pulse_window) : gate_stage;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_prev <= 1'b0;
            toggle_ff <= 1'b0;
            stage_prev <= 1'b0;
            pulse_window <= 1'b0;
            gate_level_status <= 1'b0;
            status_prev <= 1'b0;
        end else begin
            source_prev <= source_pol;
            stage_prev <= gate_stage;
            gate_level_status <= gate_level;
            status_prev <= gate_level_status;
            if (!gate_toggle_mode_bit || !counter_on_bit) begin
                toggle_ff <= 1'b0;
            end else if (source_rise) begin
                toggle_ff <= !toggle_ff;
            end
            if (!gate_single_pulse_bit || !counter_on_bit) begin
                pulse_window <= 1'b0;
            end else if (stage_fall) begin
                pulse_window <= 1'b0;
            end else if (stage_rise && pulse_acquire_go_done) begin
                pulse_window <= 1'b1;
            end
        end
    end

    // count clock: every pclk or rising edge of pin
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_prev <= 1'b0;
        end else begin
            clock_prev <= count_clock_s;
        end
    end

    assign tick = external_clock_select ?
        (count_clock_s && !clock_prev) : 1'b1;
    assign count_enable = counter_on_bit &&
        (!gate_enable_bit || gate_level_status);
    assign increment = count_enable && tick;
    assign rollover = increment && (count == `COUNT_MAX);

    // counter; a bus write wins over an increment
    always @* begin
        next_count = count;
        if (increment) begin
            next_count = count + `COUNT_ONE;
        end
        if (wr && addr == `OFS_COUNT_LOW) begin
            next_count = {count[15:8], pwdata[7:0]};
        end
        if (wr && addr == `OFS_COUNT_HIGH) begin
            next_count = {pwdata[7:0], count[7:0]};
        end
    end

    // go/done: software arms, trailing edge ends
    always @* begin
        next_go_done = pulse_acquire_go_done;
        if (pulse_window && stage_fall) begin
            next_go_done = 1'b0;
        end
        if (wr && addr == `OFS_GATE_CTRL) begin
            if (pwdata[`GC_GO_DONE] && pwdata[`GC_SPM]) begin
                next_go_done = 1'b1;
            end
        end
        if (!gate_single_pulse_bit ||
            (wr && addr == `OFS_GATE_CTRL && !pwdata[`GC_SPM])) begin
            next_go_done = 1'b0;
        end
    end

    // sticky flags, hardware set wins over software write
    always @* begin
        next_overflow_flag = overflow_flag;
        next_gate_event_flag = gate_event_flag;
        if (wr && addr == `OFS_FLAGS) begin
            next_overflow_flag = pwdata[`FL_OVERFLOW];
            next_gate_event_flag = pwdata[`FL_GATE];
        end
        if (rollover) begin
            next_overflow_flag = 1'b1;
        end
        if (status_prev && !gate_level_status) begin
            next_gate_event_flag = 1'b1;
        end
    end

    // register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_on_bit <= 1'b0;
            external_clock_select <= 1'b0;
            gate_enable_bit <= 1'b0;
            gate_polarity_bit <= 1'b0;
            gate_toggle_mode_bit <= 1'b0;
            gate_single_pulse_bit <= 1'b0;
            pulse_acquire_go_done <= 1'b0;
            gate_source_select <= `GSS_PIN;
            count <= `COUNT_ZERO;
            overflow_flag <= 1'b0;
            gate_event_flag <= 1'b0;
            overflow_irq_enable <= 1'b0;
            gate_event_irq_enable <= 1'b0;
            peripheral_irq_enable <= 1'b0;
            global_irq_enable <= 1'b0;
            watchdog_config_enable <= 1'b0;
        end else begin
            count <= next_count;
            pulse_acquire_go_done <= next_go_done;
            overflow_flag <= next_overflow_flag;
            gate_event_flag <= next_gate_event_flag;
            if (wr && addr == `OFS_COUNTER_CTRL) begin
                counter_on_bit <= pwdata[`CC_ON];
                external_clock_select <= pwdata[`CC_EXT_CLK];
            end
            if (wr && addr == `OFS_GATE_CTRL) begin
                gate_enable_bit <= pwdata[`GC_GE];
                gate_polarity_bit <= pwdata[`GC_POL];
                gate_toggle_mode_bit <= pwdata[`GC_TM];
                gate_single_pulse_bit <= pwdata[`GC_SPM];
                gate_source_select <= pwdata[`GC_GSS_HI:`GC_GSS_LO];
            end
            if (wr && addr == `OFS_IRQ_ENABLES) begin
                overflow_irq_enable <= pwdata[`FL_OVERFLOW];
                gate_event_irq_enable <= pwdata[`FL_GATE];
            end
            if (wr && addr == `OFS_SYSTEM_CTRL) begin
                peripheral_irq_enable <= pwdata[`SC_PERIPH_IE];
                global_irq_enable <= pwdata[`SC_GLOBAL_IE];
                watchdog_config_enable <= pwdata[`SC_WDT_CFG];
            end
        end
    end

    // read data captured in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `WORD_ZERO;
        end else if (setup && !pwrite && !mapped) begin
            prdata <= `WORD_ZERO;
        end else if (setup && !pwrite) begin
            prdata <= `WORD_ZERO;
            case (addr)
                `OFS_COUNTER_CTRL: begin
                    prdata[`CC_ON] <= counter_on_bit;
                    prdata[`CC_EXT_CLK] <= external_clock_select;
                end
                `OFS_GATE_CTRL: begin
                    prdata[`GC_GE] <= gate_enable_bit;
                    prdata[`GC_POL] <= gate_polarity_bit;
                    prdata[`GC_TM] <= gate_toggle_mode_bit;
                    prdata[`GC_SPM] <= gate_single_pulse_bit;
                    prdata[`GC_GO_DONE] <= pulse_acquire_go_done;
                    prdata[`GC_GVAL] <= gate_level_status;
                    prdata[`GC_GSS_HI:`GC_GSS_LO] <= gate_source_select;
                end
                `OFS_COUNT_LOW: begin
                    prdata[7:0] <= count[7:0];
                end
                `OFS_COUNT_HIGH: begin
                    prdata[7:0] <= count[15:8];
                end
                `OFS_FLAGS: begin
                    prdata[`FL_OVERFLOW] <= overflow_flag;
                    prdata[`FL_GATE] <= gate_event_flag;
                end
                `OFS_IRQ_ENABLES: begin
                    prdata[`FL_OVERFLOW] <= overflow_irq_enable;
                    prdata[`FL_GATE] <= gate_event_irq_enable;
                end
                `OFS_SYSTEM_CTRL: begin
                    prdata[`SC_PERIPH_IE] <= peripheral_irq_enable;
                    prdata[`SC_GLOBAL_IE] <= global_irq_enable;
                    prdata[`SC_WDT_CFG] <= watchdog_config_enable;
                end
                default: begin
                    prdata <= `WORD_ZERO;
                end
            endcase
        end
    end

    // watchdog enables and interrupt requests
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_run <= 1'b0;
            watchdog_reset_enable <= 1'b0;
            overflow_irq <= 1'b0;
            gate_event_irq <= 1'b0;
            irq_request <= 1'b0;
        end else begin
            watchdog_run <= watchdog_config_enable || (gate_enable_bit &&
                gate_source_select == `GSS_WATCHDOG);
            watchdog_reset_enable <= watchdog_config_enable;
            overflow_irq <= overflow_flag && overflow_irq_enable &&
                counter_on_bit;
            gate_event_irq <= gate_event_flag &&
                gate_event_irq_enable;
            irq_request <= global_irq_enable && peripheral_irq_enable &&
                ((overflow_flag && overflow_irq_enable &&
                  counter_on_bit) ||
                 (gate_event_flag && gate_event_irq_enable));
        end
    end

endmodule

/* File: verification/gate_sources_model.sv */
`timescale 1ns/100ps
module gate_sources_model (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // bench commands
    input wire gate_level,
    input wire fire,
    input wire [1:0] fire_src,
    // gate sources toward the block
    output wire gate_input,
    output wire count_clock,
    output wire [7:0] divider_timer_count,
    output wire [7:0] aux_timer_count,
    output wire [7:0] aux_period_register,
    output wire aux_increment,
    output wire watchdog_overflow
);
    reg [2:0] step;
    reg [1:0] src;
    reg [2:0] ck;
    // one source event per fire, plus a free count clock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step <= 3'h0;
            src <= 2'h0;
            ck <= 3'h0;
        end else begin
            ck <= ck + 3'h1;
            if (fire) begin
                step <= 3'h1;
                src <= fire_src;
            end else if (step != 3'h0) begin
                step <= step + 3'h1;
            end
        end
    end
    // pin level passes straight through; external clock is pclk divided by eight
    assign gate_input = gate_level;
    assign count_clock = ck[2];
    // divider wraps ff to 00 once per event
    assign divider_timer_count = (src != 2'h1 || step == 3'h0) ? 8'h80 :
        (step == 3'h1) ? 8'hFF : 8'h00;
    // aux timer at period, reset to 00 on the next increment
    assign aux_period_register = 8'h05;
    assign aux_increment = src == 2'h2 && step == 3'h1;
    assign aux_timer_count = (src != 2'h2 || step == 3'h0) ? 8'h03 :
        aux_increment ? 8'h05 : 8'h00;
    // watchdog overflow on each watchdog fire, held four cycles
    assign watchdog_overflow = src == 2'h3 && step != 3'h0 &&
        step < 3'h5;
endmodule

/* File: verification/gated_timer_checker.sv */
`timescale 1ns/100ps
`include "gate_timer_regs.vh"
module gated_timer_checker (
    // apb side
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire [31:0] prdata,
    // watchdog and interrupt outputs
    input wire watchdog_run,
    input wire watchdog_reset_enable,
    input wire overflow_irq,
    input wire gate_event_irq,
    input wire irq_request
);
    wire acc = psel && penable && pready;
    reg cc_on;
    reg [7:0] gc;
    reg [1:0] ie;
    reg [2:0] sc;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // shadow of the control bits software wrote
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cc_on <= 1'b0;
            gc <= 8'h00;
            ie <= 2'b00;
            sc <= 3'b000;
        end else if (acc && pwrite) begin
            case (paddr[7:0])
                `OFS_COUNTER_CTRL: cc_on <= pwdata[`CC_ON];
                `OFS_GATE_CTRL: gc <= pwdata[7:0];
                `OFS_IRQ_ENABLES: ie <= pwdata[1:0];
                `OFS_SYSTEM_CTRL: sc <= pwdata[2:0];
                default: ;
            endcase
        end
    end
    sequence s_rd(ofs);
        acc && !pwrite && paddr[7:0] == ofs;
    endsequence
    chk_wdt_run_src: assert property (
        watchdog_run == $past(sc[2] || (gc[7] && gc[1:0] == 2'b11)))
        else $error("watchdog run mismatch");
    chk_wdt_rst_cfg: assert property (
        watchdog_reset_enable == $past(sc[`SC_WDT_CFG]))
        else $error("watchdog reset enable mismatch");
    chk_irq_gated: assert property (
        irq_request |-> $past(sc[0] && sc[1]))
        else $error("irq request without enables");
    chk_ovf_irq_en: assert property (
        overflow_irq |-> $past(cc_on && ie[0]))
        else $error("overflow irq without enables");
    chk_gate_irq_en: assert property (
        gate_event_irq |-> $past(ie[1]))
        else $error("gate irq without enable");
    chk_count_byte: assert property (
        s_rd(`OFS_COUNT_LOW) or s_rd(`OFS_COUNT_HIGH)
        |-> prdata[31:8] == 24'h00_0000)
        else $error("count half wider than a byte");
    chk_go_cleared: assert property (
        s_rd(`OFS_GATE_CTRL) ##0 !gc[`GC_SPM] |-> !prdata[`GC_GO_DONE])
        else $error("go bit set with single pulse off");
    chk_gss_kept: assert property (
        s_rd(`OFS_GATE_CTRL)
        |-> prdata[1:0] == gc[1:0] && prdata[7:4] == gc[7:4])
        else $error("gate control readback mismatch");
endmodule
bind gated_timer_gate_and_irq gated_timer_checker gated_timer_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .watchdog_run(watchdog_run),
    .watchdog_reset_enable(watchdog_reset_enable),
    .overflow_irq(overflow_irq), .gate_event_irq(gate_event_irq),
    .irq_request(irq_request)
);

/* File: verification/testbench.sv */
`timescale 1ns/100ps
`include "gate_timer_regs.vh"
module testbench;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [31:0] paddr = 32'h0000_0000;
    reg [31:0] pwdata = 32'h0000_0000;
    reg gate_level = 1'b0;
    reg fire = 1'b0;
    reg [1:0] fire_src = 2'h0;
    wire pready, pslverr, gate_input, count_clock, aux_increment;
    wire watchdog_overflow, watchdog_run, watchdog_reset_enable;
    wire overflow_irq, gate_event_irq, irq_request;
    wire [31:0] prdata;
    wire [7:0] divider_timer_count, aux_timer_count, aux_period_register;
    reg [31:0] rdata;
    reg slverr;
    reg [7:0] a;
    integer err_count = 0;
    integer compares = 0;
    integer i;
    gated_timer_gate_and_irq gated_timer_gate_and_irq_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .gate_input(gate_input),
        .count_clock(count_clock),
        .divider_timer_count(divider_timer_count),
        .aux_timer_count(aux_timer_count),
        .aux_period_register(aux_period_register),
        .aux_increment(aux_increment),
        .watchdog_overflow(watchdog_overflow), .watchdog_run(watchdog_run),
        .watchdog_reset_enable(watchdog_reset_enable),
        .overflow_irq(overflow_irq), .gate_event_irq(gate_event_irq),
        .irq_request(irq_request)
    );
    gate_sources_model gate_sources_model_inst (
        .pclk(pclk), .presetn(presetn), .gate_level(gate_level),
        .fire(fire), .fire_src(fire_src), .gate_input(gate_input),
        .count_clock(count_clock),
        .divider_timer_count(divider_timer_count),
        .aux_timer_count(aux_timer_count),
        .aux_period_register(aux_period_register),
        .aux_increment(aux_increment),
        .watchdog_overflow(watchdog_overflow)
    );
    // 10 mhz clock
    always #50 pclk = ~pclk;
    task tally_and_finish;
        if (err_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer, read data kept in rdata
    task apb(input [7:0] ofs, input w, input [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h00_0000, ofs};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input [7:0] ofs, input [31:0] d);
        apb(ofs, 1'b1, d);
    endtask
    task rd(input [7:0] ofs);
        apb(ofs, 1'b0, `WORD_ZERO);
    endtask
    task idle(input integer n);
        repeat (n) @(posedge pclk);
    endtask
    // counter stopped before its halves are written
    task zero_count;
        wr(`OFS_COUNTER_CTRL, `WORD_ZERO);
        wr(`OFS_COUNT_LOW, `WORD_ZERO);
        wr(`OFS_COUNT_HIGH, `WORD_ZERO);
    endtask
    task pulse(input [1:0] s);
        @(posedge pclk);
        fire_src <= s;
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
    endtask
    task irq_off;
        wr(`OFS_FLAGS, `WORD_ZERO);
        wr(`OFS_IRQ_ENABLES, `WORD_ZERO);
        wr(`OFS_SYSTEM_CTRL, `WORD_ZERO);
    endtask
    // status bit read-only, follows the pin; unmapped read refused
    task t_status;
        rd(`OFS_GATE_CTRL);
        check(rdata & 32'hFFFF_FFFB, `WORD_ZERO);
        wr(`OFS_GATE_CTRL, 32'h0000_0044);
        idle(6);
        rd(`OFS_GATE_CTRL);
        check(rdata, 32'h0000_0040);
        gate_level <= 1'b1;
        idle(6);
        rd(`OFS_GATE_CTRL);
        check(rdata, 32'h0000_0044);
        rd(8'h1C);
        check(slverr, 1'b1);
        check(rdata, `WORD_ZERO);
    endtask
    // counter off holds, a stop freezes the count
    task t_free;
        wr(`OFS_GATE_CTRL, 32'h0000_0080);
        zero_count;
        idle(5);
        rd(`OFS_COUNT_LOW);
        check(rdata, `WORD_ZERO);
        wr(`OFS_GATE_CTRL, `WORD_ZERO);
        wr(`OFS_COUNTER_CTRL, 32'h0000_0001);
        wr(`OFS_COUNTER_CTRL, `WORD_ZERO);
        rd(`OFS_COUNT_LOW);
        a = rdata[7:0];
        idle(5);
        rd(`OFS_COUNT_LOW);
        check(rdata[7:0], a);
        check(a != 8'h00, 1'b1);
        zero_count;
        wr(`OFS_COUNTER_CTRL, 32'h0000_0003);
        idle(64);
        wr(`OFS_COUNTER_CTRL, `WORD_ZERO);
        rd(`OFS_COUNT_LOW);
        check(rdata[7:0] > 8'h06 && rdata[7:0] < 8'h0A, 1'b1);
    endtask
    // all polarity and pin pairs, gating on
    task t_gate;
        wr(`OFS_COUNTER_CTRL, 32'h0000_0001);
        for (i = 0; i < 4; i++) begin
            gate_level <= i[0];
            wr(`OFS_GATE_CTRL, {24'h00_0000, 1'b1, i[1], 6'h00});
            idle(8);
            rd(`OFS_GATE_CTRL);
            check(rdata[`GC_GVAL], i[0] == i[1]);
            rd(`OFS_COUNT_LOW);
            a = rdata[7:0];
            idle(10);
            rd(`OFS_COUNT_LOW);
            check(rdata[7:0] != a, i[0] == i[1]);
        end
    endtask
    // rollover sets the flag, irq_request only with every enable, overflow_irq without the global enable
    task t_ovf;
        wr(`OFS_GATE_CTRL, `WORD_ZERO);
        zero_count;
        wr(`OFS_COUNT_LOW, 32'h0000_00F0);
        wr(`OFS_COUNT_HIGH, 32'h0000_00FF);
        rd(`OFS_COUNT_HIGH);
        check(rdata, 32'h0000_00FF);
        irq_off;
        wr(`OFS_IRQ_ENABLES, 32'h0000_0001);
        wr(`OFS_SYSTEM_CTRL, 32'h0000_0003);
        wr(`OFS_COUNTER_CTRL, 32'h0000_0001);
        idle(20);
        rd(`OFS_FLAGS);
        check(rdata[`FL_OVERFLOW], 1'b1);
        check({overflow_irq, irq_request}, 2'b11);
        wr(`OFS_SYSTEM_CTRL, 32'h0000_0001);
        idle(3);
        check({overflow_irq, irq_request}, 2'b10);
        irq_off;
    endtask
    // falling status sets the gate flag with gating off
    task t_gflag;
        wr(`OFS_GATE_CTRL, 32'h0000_0040);
        idle(8);
        wr(`OFS_FLAGS, `WORD_ZERO);
        wr(`OFS_IRQ_ENABLES, 32'h0000_0002);
        wr(`OFS_SYSTEM_CTRL, 32'h0000_0007);
        gate_level <= 1'b0;
        idle(8);
        rd(`OFS_FLAGS);
        check(rdata[1:0], 2'b10);
        check({gate_event_irq, irq_request}, 2'b11);
        check({watchdog_run, watchdog_reset_enable}, 2'b11);
        irq_off;
    endtask
    // internal sources through the toggle flop, one event each
    task t_src;
        for (i = 1; i < 4; i++) begin
            zero_count;
            wr(`OFS_GATE_CTRL, {24'h00_0000, 6'h38, i[1:0]});
            idle(3);
            check(watchdog_run, i == 3);
            check(watchdog_reset_enable, 1'b0);
            wr(`OFS_COUNTER_CTRL, 32'h0000_0001);
            idle(10);
            rd(`OFS_COUNT_LOW);
            check(rdata[7:0], 8'h00);
            pulse(i[1:0]);
            idle(12);
            rd(`OFS_COUNT_LOW);
            check(rdata[7:0] != 8'h00, 1'b1);
        end
    endtask
    // single pulse: armed, counts one pulse, then blocked
    task t_spm;
        gate_level <= 1'b0;
        zero_count;
        wr(`OFS_GATE_CTRL, 32'h0000_00D0);
        wr(`OFS_COUNTER_CTRL, 32'h0000_0001);
        wr(`OFS_GATE_CTRL, 32'h0000_00D8);
        idle(10);
        rd(`OFS_COUNT_LOW);
        check(rdata[7:0], 8'h00);
        gate_level <= 1'b1;
        idle(10);
        gate_level <= 1'b0;
        idle(8);
        rd(`OFS_GATE_CTRL);
        check(rdata[`GC_GO_DONE], 1'b0);
        rd(`OFS_COUNT_LOW);
        a = rdata[7:0];
        check(a != 8'h00, 1'b1);
        gate_level <= 1'b1;
        idle(10);
        gate_level <= 1'b0;
        rd(`OFS_COUNT_LOW);
        check(rdata[7:0], a);
        wr(`OFS_GATE_CTRL, 32'h0000_00D8);
        wr(`OFS_GATE_CTRL, 32'h0000_00C8);
        rd(`OFS_GATE_CTRL);
        check(rdata[`GC_GO_DONE], 1'b0);
    endtask
    // toggle plus single pulse: one full gate cycle counted
    task t_spm_tgl;
        zero_count;
        wr(`OFS_GATE_CTRL, 32'h0000_00F0);
        wr(`OFS_COUNTER_CTRL, 32'h0000_0001);
        wr(`OFS_GATE_CTRL, 32'h0000_00F8);
        for (i = 0; i < 6; i++) begin
            gate_level <= ~gate_level;
            idle(6);
            if (i == 3) begin
                rd(`OFS_COUNT_LOW);
                a = rdata[7:0];
            end
        end
        rd(`OFS_COUNT_LOW);
        check(rdata[7:0], a);
        check(a > 8'h08, 1'b1);
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_status;
        t_free;
        t_gate;
        t_ovf;
        t_gflag;
        t_src;
        t_spm;
        t_spm_tgl;
        tally_and_finish;
    end
    // hang guard, far beyond the expected run length
    initial begin
        #(100 * 5000);
        err_count++;
        tally_and_finish;
    end
endmodule
